/* sjt_ctrl_model.sv */
// boundary scan controller model driving the test port pins
`timescale 1ns/1ps
module sjt_ctrl_model (
  input wire ref_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire tdo,
  input wire tdoOe_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one tck period is 16 system clocks; tck idles low between frames
  task automatic step(input logic m, input logic d, output logic b);
    @(posedge ref_clk);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge ref_clk);
    b = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge ref_clk);
    tck <= 1'b0;
    // released data line shows the inverse, not a stale copy
    tdi <= ~d;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic reset5();
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
  // from idle: ir selects instruction path; ends back in idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule // sjt_ctrl_model

/* sjt_sram_jtag_tap.v */
// test access port of the sram: state machine, instruction, id, bypass and boundary ring
`timescale 1ns/1ps
`include "sram_jtag_regs.vh"
module sjt_sram_jtag_tap #(
  parameter BSR_W = `SJT_BSR_W,
  parameter [2:0] ID_REVISION = 3'h0,      // arbitrary value
  parameter [16:0] ID_PART = 17'h0_0ABC,   // arbitrary value
  parameter [10:0] ID_MFR = 11'h055        // arbitrary value
) (
  input wire ref_clk,
  input wire arst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  output wire tdo,
  output wire tdoOe_n,
  input wire [BSR_W-1:0] ringIn,
  output wire [BSR_W-1:0] ringDrive,
  output wire extestActive,
  output wire qBusDrive,
  output wire qBusHiZ,
  output wire [3:0] tapState
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // next controller state for the tms level seen at a tck rise
  function [3:0] stepState;
    input [3:0] cur;
    input m;
    begin
      case (cur)
        `SJT_ST_RESET: stepState = m ? `SJT_ST_RESET : `SJT_ST_IDLE;
        `SJT_ST_IDLE: stepState = m ? `SJT_ST_SEL_DR : `SJT_ST_IDLE;
        `SJT_ST_SEL_DR: stepState = m ? `SJT_ST_SEL_IR : `SJT_ST_CAP_DR;
        `SJT_ST_CAP_DR: stepState = m ? `SJT_ST_EX1_DR : `SJT_ST_SHF_DR;
        `SJT_ST_SHF_DR: stepState = m ? `SJT_ST_EX1_DR : `SJT_ST_SHF_DR;
        `SJT_ST_EX1_DR: stepState = m ? `SJT_ST_UPD_DR : `SJT_ST_PAU_DR;
        `SJT_ST_PAU_DR: stepState = m ? `SJT_ST_EX2_DR : `SJT_ST_PAU_DR;
        `SJT_ST_EX2_DR: stepState = m ? `SJT_ST_UPD_DR : `SJT_ST_SHF_DR;
        `SJT_ST_UPD_DR: stepState = m ? `SJT_ST_SEL_DR : `SJT_ST_IDLE;
        `SJT_ST_SEL_IR: stepState = m ? `SJT_ST_RESET : `SJT_ST_CAP_IR;
        `SJT_ST_CAP_IR: stepState = m ? `SJT_ST_EX1_IR : `SJT_ST_SHF_IR;
        `SJT_ST_SHF_IR: stepState = m ? `SJT_ST_EX1_IR : `SJT_ST_SHF_IR;
        `SJT_ST_EX1_IR: stepState = m ? `SJT_ST_UPD_IR : `SJT_ST_PAU_IR;
        `SJT_ST_PAU_IR: stepState = m ? `SJT_ST_EX2_IR : `SJT_ST_PAU_IR;
        `SJT_ST_EX2_IR: stepState = m ? `SJT_ST_UPD_IR : `SJT_ST_SHF_IR;
        `SJT_ST_UPD_IR: stepState = m ? `SJT_ST_SEL_DR : `SJT_ST_IDLE;
        default: stepState = `SJT_ST_RESET;
      endcase
    end
  endfunction

  // boundary chain is the data path for these three codes
  function usesRing;
    input [2:0] op;
    begin
      usesRing = (op == `SJT_OP_EXTEST) || (op == `SJT_OP_HIZ_SAMPLE) || (op == `SJT_OP_SAMPLE);
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers and test clock edges
  // ----------------------------------------
  reg tckMeta_reg, tckSync_reg, tckPrev_reg;
  reg tmsMeta_reg, tmsSync_reg;
  reg tdiMeta_reg, tdiSync_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tckMeta_reg <= 1'b0;
      tckSync_reg <= 1'b0;
      tckPrev_reg <= 1'b0;
      tmsMeta_reg <= `SJT_TMS_RESET_VAL;
      tmsSync_reg <= `SJT_TMS_RESET_VAL;
      tdiMeta_reg <= 1'b0;
      tdiSync_reg <= 1'b0;
    end else begin
      tckMeta_reg <= tck;
      tckSync_reg <= tckMeta_reg;
      tckPrev_reg <= tckSync_reg;
      tmsMeta_reg <= tms;
      tmsSync_reg <= tmsMeta_reg;
      tdiMeta_reg <= tdi;
      tdiSync_reg <= tdiMeta_reg;
    end
  end

  // tms and tdi lag tck by the same two stages, so the sampled level matches the edge
  // limitation: a tck phase shorter than one system clock can slip past unseen
  wire tckRise = tckSync_reg & ~tckPrev_reg;
  wire tckFall = ~tckSync_reg & tckPrev_reg;

  // ----------------------------------------
  // ring pin synchroniser
  // ----------------------------------------
  // bits settle one by one, so the ring must hold still around capture
  reg [BSR_W-1:0] ringMeta_reg;
  reg [BSR_W-1:0] ringSync_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ringMeta_reg <= {BSR_W{1'b0}};
      ringSync_reg <= {BSR_W{1'b0}};
    end else begin
      ringMeta_reg <= ringIn;
      ringSync_reg <= ringMeta_reg;
    end
  end

  // ----------------------------------------
  // test state machine
  // ----------------------------------------
  reg [3:0] state_reg;
  wire [3:0] state_next = stepState(state_reg, tmsSync_reg);
  // test-logic-reset acts on entry, not one test clock later
  wire toReset = (state_next == `SJT_ST_RESET);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= `SJT_ST_RESET;
    end else if (tckRise) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // instruction path
  // ----------------------------------------
  reg [`SJT_IR_W-1:0] irShift_reg;
  reg [`SJT_IR_W-1:0] irActive_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irShift_reg <= `SJT_IR_CAPTURE;
      irActive_reg <= `SJT_OP_IDCODE;
    end else if (tckRise) begin
      if (toReset) begin
        irActive_reg <= `SJT_OP_IDCODE;
      end
      case (state_reg)
        // upper bit captured as zero, the low two carry the fixed pattern
        `SJT_ST_CAP_IR: irShift_reg <= `SJT_IR_CAPTURE;
        `SJT_ST_SHF_IR: irShift_reg <= {tdiSync_reg, irShift_reg[`SJT_IR_W-1:1]};
        `SJT_ST_UPD_IR: irActive_reg <= irShift_reg;
        default: irShift_reg <= irShift_reg;
      endcase
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  wire [`SJT_ID_W-1:0] idValue;
  assign idValue[`SJT_ID_REV] = ID_REVISION;
  assign idValue[`SJT_ID_PART] = ID_PART;
  assign idValue[`SJT_ID_MFR] = ID_MFR;
  assign idValue[`SJT_ID_PRESENT] = `SJT_ID_PRESENT_VAL;

  reg [`SJT_ID_W-1:0] idShift_reg;
  reg bypass_reg;
  reg [BSR_W-1:0] ringShift_reg;
  reg [BSR_W-1:0] ringUpdate_reg;

  // exactly one data register is selected at a time
  wire selRing = usesRing(irActive_reg);
  wire selId = (irActive_reg == `SJT_OP_IDCODE);
  // reserved codes fall back to the bypass cell so the chain never breaks
  wire selBypass = ~selRing & ~selId;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idShift_reg <= {`SJT_ID_W{1'b0}};
      bypass_reg <= 1'b0;
      ringShift_reg <= {BSR_W{1'b0}};
      ringUpdate_reg <= {BSR_W{1'b0}};
      // output-bus cell starts high so extest drives the bus unless told otherwise
      ringUpdate_reg[`SJT_BSR_OE_CELL] <= 1'b1;
    end else if (tckRise) begin
      if (toReset) begin
        ringUpdate_reg[`SJT_BSR_OE_CELL] <= 1'b1;
      end
      case (state_reg)
        `SJT_ST_CAP_DR: begin
          if (selRing) begin
            // synchronised ring, two system clocks behind the pins
            ringShift_reg <= ringSync_reg;
          end
          if (selId) begin
            idShift_reg <= idValue;
          end
          if (selBypass) begin
            bypass_reg <= 1'b0;
          end
        end
        `SJT_ST_SHF_DR: begin
          if (selRing) begin
            ringShift_reg <= {tdiSync_reg, ringShift_reg[BSR_W-1:1]};
          end
          if (selId) begin
            idShift_reg <= {tdiSync_reg, idShift_reg[`SJT_ID_W-1:1]};
          end
          if (selBypass) begin
            bypass_reg <= tdiSync_reg;
          end
        end
        `SJT_ST_UPD_DR: begin
          if (selRing) begin
            // latched cells change only here and on entry to test-logic-reset (cell 47 preset), so the outputs hold still while shifting
            ringUpdate_reg <= ringShift_reg;
          end
        end
        default: bypass_reg <= bypass_reg;
      endcase
    end
  end

  // ----------------------------------------
  // serial out, changed on the falling edge
  // ----------------------------------------
  reg tdo_reg;
  reg tdoOe_n_reg;
  reg serialBit;
  // pin drives only while a register sits in the shift path
  wire inShift = (state_reg == `SJT_ST_SHF_IR) || (state_reg == `SJT_ST_SHF_DR);

  // instruction path wins over whatever data register is selected
  always @* begin
    serialBit = bypass_reg;
    if (state_reg == `SJT_ST_SHF_IR) begin
      serialBit = irShift_reg[0];
    end else if (selRing) begin
      serialBit = ringShift_reg[0];
    end else if (selId) begin
      serialBit = idShift_reg[0];
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo_reg <= 1'b0;
      // floats from power up so a shared scan line is never fought
      tdoOe_n_reg <= 1'b1;
    end else if (tckFall) begin
      tdo_reg <= serialBit;
      // pin floats outside the shift states
      tdoOe_n_reg <= ~inShift;
    end
  end

  // ----------------------------------------
  // memory-side controls
  // ----------------------------------------
  // controls follow the latched cell, never the one still shifting
  wire opExtest = (irActive_reg == `SJT_OP_EXTEST);
  wire opHiZSample = (irActive_reg == `SJT_OP_HIZ_SAMPLE);
  wire oeCell = ringUpdate_reg[`SJT_BSR_OE_CELL];

  reg extest_reg;
  reg qDrive_reg;
  reg qHiZ_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      extest_reg <= 1'b0;
      qDrive_reg <= 1'b0;
      qHiZ_reg <= 1'b0;
    end else begin
      extest_reg <= opExtest;
      qDrive_reg <= opExtest & oeCell;
      qHiZ_reg <= opHiZSample | (opExtest & ~oeCell);
    end
  end

  assign tdo = tdo_reg;
  assign tdoOe_n = tdoOe_n_reg;
  assign ringDrive = ringUpdate_reg;
  assign extestActive = extest_reg;
  assign qBusDrive = qDrive_reg;
  assign qBusHiZ = qHiZ_reg;
  assign tapState = state_reg;

endmodule // sjt_sram_jtag_tap

/* sjt_sram_jtag_tap_tb_top.sv */
// self-checking bench for the sram test access port
`timescale 1ns/1ps
`include "sram_jtag_regs.vh"
module sjt_sram_jtag_tap_tb_top;
  localparam int BSR_W = 107;
  localparam logic [2:0] REV = 3'h5; // arbitrary value
  localparam logic [16:0] PART = 17'h1_2345; // arbitrary value
  localparam logic [10:0] MFR = 11'h2A7; // arbitrary value
  localparam logic [31:0] IDV = {REV, PART, MFR, 1'b1};
  localparam logic [106:0] RING = 107'h4A5_C30F_961E_2D3C_4B5A_6978_87AB;
  localparam logic [106:0] NRING = ~RING;
  logic ref_clk, arst_n, tck, tms, tdi, tdo, tdoOe_n, extestActive, qBusDrive, qBusHiZ;
  logic [106:0] ringIn, ringDrive;
  logic [3:0] tapState;
  logic [127:0] got;
  int nMismatch = 0;
  int cmpCount = 0;
  sjt_sram_jtag_tap #(.BSR_W(BSR_W), .ID_REVISION(REV), .ID_PART(PART), .ID_MFR(MFR)) DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe_n(tdoOe_n), .ringIn(ringIn), .ringDrive(ringDrive), .extestActive(extestActive),
    .qBusDrive(qBusDrive), .qBusHiZ(qBusHiZ), .tapState(tapState));
  sjt_ctrl_model ctrl (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe_n(tdoOe_n));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [127:0] g, input logic [127:0] e, input string what);
    cmpCount++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic conclude();
    if (nMismatch == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // whole sequence needs about 76 us
  initial begin
    #400us;
    nMismatch++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    ringIn = '0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    chk(tapState, `SJT_ST_RESET, "state at reset");
    chk(ringDrive, 128'h1 << `SJT_BSR_OE_CELL, "ring at reset");
    chk({tdoOe_n, extestActive, qBusDrive, qBusHiZ}, 4'h8, "pins at reset");
    ctrl.reset5();
    ctrl.scan(1'b0, 32, '0, got);
    chk(got, IDV, "id code");
    ctrl.scan(1'b1, 3, 128'h7, got);
    chk(got, 128'h1, "ir capture");
    ctrl.scan(1'b0, 8, 128'h00B5, got);
    chk(got, 128'h006A, "bypass path");
    @(posedge ref_clk) ringIn <= RING;
    ctrl.scan(1'b1, 3, 128'h4, got);
    ctrl.scan(1'b0, 108, {RING, 1'b1}, got);
    chk(got, {1'b1, RING}, "sample chain");
    chk(ringDrive, RING, "preload");
    chk({extestActive, qBusDrive, qBusHiZ}, 3'h0, "sample bus");
    ctrl.scan(1'b1, 3, 128'h0, got);
    chk({extestActive, qBusDrive, qBusHiZ}, 3'h5, "extest cell low");
    ctrl.scan(1'b0, 108, {NRING, 1'b0}, got);
    chk(got, {1'b0, RING}, "extest chain");
    chk({extestActive, qBusDrive, qBusHiZ}, 3'h6, "extest cell high");
    ctrl.scan(1'b1, 3, 128'h2, got);
    chk({extestActive, qBusDrive, qBusHiZ}, 3'h1, "sample z bus");
    ctrl.scan(1'b0, 107, '0, got);
    chk(got, RING, "sample z chain");
    ctrl.reset5();
    chk({extestActive, qBusDrive, qBusHiZ, ringDrive[47]}, 4'h1, "after tap reset");
    ctrl.scan(1'b0, 32, '0, got);
    chk(got, IDV, "id after reset");
    conclude();
  end
endmodule // sjt_sram_jtag_tap_tb_top
bind sjt_sram_jtag_tap sjt_tap_properties #(.BSR_W(BSR_W)) props (
  .ref_clk(ref_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdoOe_n(tdoOe_n), .ringIn(ringIn), .ringDrive(ringDrive), .extestActive(extestActive),
  .qBusDrive(qBusDrive), .qBusHiZ(qBusHiZ), .tapState(tapState));

/* sjt_tap_properties.sv */
// concurrent checks on the test access port pins
`timescale 1ns/1ps
`include "sram_jtag_regs.vh"
module sjt_tap_properties #(
  parameter BSR_W = 107
) (
  input wire ref_clk,
  input wire arst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire tdo,
  input wire tdoOe_n,
  input wire [BSR_W-1:0] ringIn,
  input wire [BSR_W-1:0] ringDrive,
  input wire extestActive,
  input wire qBusDrive,
  input wire qBusHiZ,
  input wire [3:0] tapState
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_leaveUpdIr;
    $changed(tapState) ##0 $past(tapState) == `SJT_ST_UPD_IR;
  endsequence
  sequence s_shiftIrOpen;
    $fell(tdoOe_n) ##0 tapState == `SJT_ST_SHF_IR;
  endsequence
  state_on_rise_a: assert property ($changed(tapState) |-> tck) else $error("state moved, tck low");
  tdo_on_fall_a: assert property ($changed(tdo) |-> !tck) else $error("tdo moved, tck high");
  oe_in_shift_a: assert property (!tdoOe_n |-> tapState inside {`SJT_ST_SHF_DR, `SJT_ST_EX1_DR,
    `SJT_ST_SHF_IR, `SJT_ST_EX1_IR}) else $error("tdo driven outside shift");
  upd_next_a: assert property (s_leaveUpdIr |-> tapState == (tms ? `SJT_ST_SEL_DR : `SJT_ST_IDLE))
    else $error("bad state after update");
  cell47_preset_a: assert property (tapState == `SJT_ST_RESET |-> ##1 ringDrive[`SJT_BSR_OE_CELL])
    else $error("cell 47 not preset");
  reset_idcode_a: assert property (tapState == `SJT_ST_RESET |-> ##2 !(extestActive || qBusHiZ || qBusDrive))
    else $error("reset left ring mode");
  qbus_cause_a: assert property (qBusDrive |-> extestActive && $past(ringDrive[`SJT_BSR_OE_CELL]))
    else $error("bus driven without cause");
  hiz_excl_a: assert property (qBusHiZ |-> !qBusDrive && !(extestActive && $past(ringDrive[`SJT_BSR_OE_CELL])))
    else $error("bus float wrong");
  ir_capture_a: assert property (s_shiftIrOpen |-> tdo) else $error("ir capture bit0 not 1");
endmodule // sjt_tap_properties

/* sram_jtag_regs.vh */
// constants for the sram test access port: states, codes, field layout
`ifndef SRAM_JTAG_REGS_VH
`define SRAM_JTAG_REGS_VH

// ----------------------------------------
// test state machine codes
// ----------------------------------------
`define SJT_ST_RESET 4'h0
`define SJT_ST_IDLE 4'h1
`define SJT_ST_SEL_DR 4'h2
`define SJT_ST_CAP_DR 4'h3
`define SJT_ST_SHF_DR 4'h4
`define SJT_ST_EX1_DR 4'h5
`define SJT_ST_PAU_DR 4'h6
`define SJT_ST_EX2_DR 4'h7
`define SJT_ST_UPD_DR 4'h8
`define SJT_ST_SEL_IR 4'h9
`define SJT_ST_CAP_IR 4'hA
`define SJT_ST_SHF_IR 4'hB
`define SJT_ST_EX1_IR 4'hC
`define SJT_ST_PAU_IR 4'hD
`define SJT_ST_EX2_IR 4'hE
`define SJT_ST_UPD_IR 4'hF

// ----------------------------------------
// instruction codes and widths
// ----------------------------------------
`define SJT_IR_W 3
`define SJT_OP_EXTEST 3'h0
`define SJT_OP_IDCODE 3'h1
`define SJT_OP_HIZ_SAMPLE 3'h2
`define SJT_OP_SAMPLE 3'h4
`define SJT_OP_BYPASS 3'h7
`define SJT_IR_CAPTURE 3'h1
`define SJT_IR_CAP_LSB 1:0

// ----------------------------------------
// identification register layout
// ----------------------------------------
`define SJT_ID_W 32
`define SJT_ID_REV 31:29
`define SJT_ID_PART 28:12
`define SJT_ID_MFR 11:1
`define SJT_ID_PRESENT 0
`define SJT_ID_PRESENT_VAL 1'h1

// ----------------------------------------
// boundary ring
// ----------------------------------------
`define SJT_BSR_W 107
`define SJT_BSR_OE_CELL 47
`define SJT_TMS_RESET_VAL 1'h1

`endif
